// ### shared/pbs_pkg.sv
// Package for the pipelined burst synchronous memory block.
// Assumes a single rising-edge clock domain; no software registers.
package pbs_pkg;
  localparam int WORD_W = 36;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 20;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FAST_GRADE_MHZ = 250;
  localparam int SLOW_GRADE_MHZ = 167;
  localparam int FAST_PERIOD_PS = 1000000 / FAST_GRADE_MHZ;
  localparam int SLOW_PERIOD_PS = 1000000 / SLOW_GRADE_MHZ;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic MODE_INTERLEAVED = 1'b0;
  localparam logic MODE_LINEAR = 1'b1;
  typedef enum logic [2:0] {
    PBS_IDLE = 3'b001,
    PBS_READ = 3'b010,
    PBS_WRITE = 3'b100
  } pbs_state_t;
endpackage

// ### shared/pbs_stream_if.sv
// Valid/ready carrier for read data between the core and its output buffer.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
interface pbs_stream_if #(parameter int W = 36);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### src/pbs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; clock enable freezes all state.
`timescale 1ns/100ps
module pbs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  pbs_stream_if.snk wr,
  pbs_stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW:0] count;
  logic push;
  logic pop;
  assign wr.ready = (count != (PW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rptr];
  assign push = clk_en && wr.valid && wr.ready;
  assign pop = clk_en && rd.valid && rd.ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + PW'(1);
      end
      if (pop) begin
        rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ### src/pbs_sram.sv
// Pipelined burst synchronous memory core with registered inputs and outputs.
// Assumes the controller drives all synchronous pins against ref_clk.
//
// Contract
// - All synchronous inputs registered on rising edge.
// - Either strobe latches address and chip enables.
// - Two independent strobes, processor and controller.
// - Advance input steps internally formed burst addresses.
// - Two-bit burst counter spans four words.
// - Burst order selectable: interleaved or linear.
// - Data outputs registered, pipelined behind request.
// - Bursts run three then one clock each.
// - Writes complete by internal timing.
// - Partial writes by per-lane select inputs.
// - Global write low writes all lanes.
// - Output enable and sleep act without clock; here dq_oe is registered and follows them at the next ref_clk edge with clk_en high.
// - Word width and depth set by variant.
// - Bus rated up to fastest grade clock.
// - Low address bits load burst counter.
// - Lane selects active low, qualified by enable.
// - Global write overrides lane selects and enable.
`timescale 1ns/100ps
module pbs_sram #(
  parameter int WORD_W = pbs_pkg::WORD_W,
  parameter int ADDR_W = pbs_pkg::ADDR_W,
  parameter int LANE_W = pbs_pkg::LANE_W,
  parameter int FIFO_DEPTH = pbs_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic pipelined_chip_enable_n,
  input wire logic depth_chip_enable_hi,
  input wire logic depth_chip_enable_lo_n,
  input wire logic [WORD_W/LANE_W-1:0] lane_write_select_n,
  input wire logic lane_write_enable_n,
  input wire logic all_lanes_write_n,
  input wire logic burst_mode,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [WORD_W-1:0] dq_in,
  input wire logic dq_ready,
  output logic [WORD_W-1:0] dq_out,
  output logic dq_oe,
  output logic dq_valid,
  output logic wr_stall
);
  localparam int LANES = WORD_W / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  logic [WORD_W-1:0] mem [DEPTH];

  // Input registers
  logic [ADDR_W-1:0] addr_q;
  logic ads_p_q;
  logic ads_c_q;
  logic adv_q;
  logic ce_q;
  logic [LANES-1:0] lane_sel_q;
  logic lane_en_q;
  logic gw_q;
  logic [WORD_W-1:0] din_q;
  logic mode_q;
  logic strobe_q;

  // Burst state
  localparam int BURST_LO = pbs_pkg::BURST_W;
  logic [ADDR_W-1:BURST_LO] base;
  logic [1:0] burst_start_low_bits;
  logic [1:0] burst_cnt;
  logic [1:0] burst_low;
  logic active;
  pbs_pkg::pbs_state_t state;
  pbs_pkg::pbs_state_t next_state;

  // Write and read path
  logic [LANES-1:0] lane_we;
  logic wr_any;
  logic rd_req;
  logic live;
  logic [ADDR_W-1:0] cur_addr;
  logic [WORD_W-1:0] rd_q;
  logic rd_q_valid;

  pbs_stream_if #(.W(WORD_W)) to_fifo ();
  pbs_stream_if #(.W(WORD_W)) from_fifo ();

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= '0;
      ads_p_q <= 1'b0;
      ads_c_q <= 1'b0;
      adv_q <= 1'b0;
      ce_q <= 1'b0;
      lane_sel_q <= '0;
      lane_en_q <= 1'b0;
      gw_q <= 1'b0;
      din_q <= '0;
      mode_q <= pbs_pkg::MODE_INTERLEAVED;
    end else if (clk_en) begin
      addr_q <= addr;
      ads_p_q <= !processor_addr_strobe_n;
      ads_c_q <= !controller_addr_strobe_n;
      adv_q <= !burst_advance_n;
      ce_q <= !pipelined_chip_enable_n && depth_chip_enable_hi && !depth_chip_enable_lo_n;
      lane_sel_q <= ~lane_write_select_n;
      lane_en_q <= !lane_write_enable_n;
      gw_q <= !all_lanes_write_n;
      din_q <= dq_in;
      mode_q <= burst_mode;
    end
  end

  assign strobe_q = ads_p_q || ads_c_q;

  // Order of words within the four-word burst
  always_comb begin
    if (mode_q == pbs_pkg::MODE_LINEAR) begin
      burst_low = burst_start_low_bits + burst_cnt;
    end else begin
      burst_low = burst_start_low_bits ^ burst_cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      base <= '0;
      burst_start_low_bits <= pbs_pkg::BURST_RESET;
      burst_cnt <= pbs_pkg::BURST_RESET;
      active <= 1'b0;
    end else if (clk_en && !sleep_request) begin
      if (strobe_q) begin
        base <= addr_q[ADDR_W-1:BURST_LO];
        burst_start_low_bits <= addr_q[1:0];
        // Counter holds the next offset; the strobe cycle itself serves offset zero
        burst_cnt <= 2'h1;
        active <= ce_q;
      end else if (adv_q && active) begin
        burst_cnt <= burst_cnt + 2'h1;
      end
      // Otherwise the counter holds and the address repeats
    end
  end

  // Strobe cycle acts on the fresh address, so a write needs no extra cycle
  assign live = strobe_q ? ce_q : active;
  assign cur_addr = strobe_q ? addr_q : {base, burst_low};

  // Global write wins over lane selects
  always_comb begin
    if (gw_q) begin
      lane_we = '1;
    end else if (lane_en_q) begin
      lane_we = lane_sel_q;
    end else begin
      lane_we = '0;
    end
  end

  // A write with the processor strobe is a read cycle on this device family
  assign wr_any = live && !ads_p_q && (|lane_we) && !sleep_request;
  assign rd_req = live && !wr_any && !sleep_request && (strobe_q || adv_q);

  always_comb begin
    next_state = pbs_pkg::PBS_IDLE;
    case (state)
      pbs_pkg::PBS_IDLE,
      pbs_pkg::PBS_READ,
      pbs_pkg::PBS_WRITE: begin
        if (wr_any) begin
          next_state = pbs_pkg::PBS_WRITE;
        end else if (rd_req) begin
          next_state = pbs_pkg::PBS_READ;
        end
      end
      default: begin
        next_state = pbs_pkg::PBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= pbs_pkg::PBS_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Self-timed array write from registered address, data and lanes
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge ref_clk) begin
      if (clk_en && wr_any && lane_we[i]) begin
        mem[cur_addr][i*LANE_W +: LANE_W] <= din_q[i*LANE_W +: LANE_W];
      end
    end
  end

  // Array read stage; the output register adds the pipeline stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= '0;
      rd_q_valid <= 1'b0;
    end else if (clk_en) begin
      rd_q_valid <= rd_req && to_fifo.ready;
      if (rd_req) begin
        rd_q <= mem[cur_addr];
      end
    end
  end

  assign to_fifo.valid = rd_q_valid;
  assign to_fifo.data = rd_q;
  assign from_fifo.ready = dq_ready;

  pbs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .wr(to_fifo),
    .rd(from_fifo)
  );

  // Output stage; enable follows the asynchronous controls one flop later
  // Limitation: a flop can only approximate a truly clockless enable.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dq_out <= '0;
      dq_valid <= 1'b0;
      dq_oe <= 1'b0;
      wr_stall <= 1'b0;
    end else if (clk_en) begin
      dq_valid <= from_fifo.valid && dq_ready;
      if (from_fifo.valid && dq_ready) begin
        dq_out <= from_fifo.data;
      end
      dq_oe <= !output_enable_n && !sleep_request;
      wr_stall <= !to_fifo.ready;
    end
  end
endmodule

// ### testbench/pbs_sram_assertions.sv
// Checker on the memory core ports.
// Assumes one clock, ref_clk, and asynchronous active-low nrst.
`timescale 1ns/100ps
module pbs_sram_chk #(parameter int WORD_W = 36) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic pipelined_chip_enable_n,
  input wire logic depth_chip_enable_hi,
  input wire logic depth_chip_enable_lo_n,
  input wire logic lane_write_enable_n,
  input wire logic all_lanes_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic dq_ready,
  input wire logic [WORD_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic dq_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_read_req;
    (!processor_addr_strobe_n || !controller_addr_strobe_n) && !pipelined_chip_enable_n && depth_chip_enable_hi &&
      !depth_chip_enable_lo_n && lane_write_enable_n && all_lanes_write_n && !sleep_request && clk_en;
  endsequence
  sequence s_drain;
    dq_ready && clk_en && !sleep_request;
  endsequence
  // Window is wide on purpose: the output buffer may add a cycle of slack
  AST_READ_LAT: assert property (s_read_req ##1 s_drain [*3] |-> ##[0:4] dq_valid)
    else $error("read word late");
  AST_RST_QUIET: assert property ($rose(nrst) |-> !dq_valid && !dq_oe && dq_out == '0)
    else $error("outputs not clear after reset");
  AST_SLEEP_OE: assert property (sleep_request && clk_en |=> !dq_oe)
    else $error("drivers on in sleep");
  AST_OE_OFF: assert property (output_enable_n && clk_en |=> !dq_oe)
    else $error("drivers on while disabled");
  AST_OE_ON: assert property (!output_enable_n && !sleep_request && clk_en |=> dq_oe)
    else $error("drivers off while enabled");
  AST_HOLD: assert property (!dq_valid |-> $stable(dq_out))
    else $error("read data moved without a word");
  AST_FREEZE: assert property (!clk_en |=> $stable(dq_out) && $stable(dq_valid))
    else $error("outputs moved while frozen");
  AST_POP: assert property (dq_valid |-> $past(dq_ready))
    else $error("word sent without consumer ready");
endmodule
bind pbs_sram pbs_sram_chk #(.WORD_W(WORD_W)) i_chk (.ref_clk, .nrst, .clk_en, .processor_addr_strobe_n,
  .controller_addr_strobe_n, .pipelined_chip_enable_n, .depth_chip_enable_hi, .depth_chip_enable_lo_n,
  .lane_write_enable_n, .all_lanes_write_n, .output_enable_n, .sleep_request, .dq_ready, .dq_out, .dq_oe, .dq_valid);

// ### testbench/pbs_ctrl_model.sv
// Controller model driving the memory's synchronous pins.
// Assumes the bench calls its tasks; pins change 1 ns after ref_clk rises.
`timescale 1ns/100ps
module pbs_ctrl_model (
  input wire logic ref_clk,
  output logic [pbs_pkg::ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  output logic pipelined_chip_enable_n,
  output logic depth_chip_enable_hi,
  output logic depth_chip_enable_lo_n,
  output logic [3:0] lane_write_select_n,
  output logic lane_write_enable_n,
  output logic all_lanes_write_n,
  output logic burst_mode,
  output logic [pbs_pkg::WORD_W-1:0] dq_in
);
  // Released data shows the inverse, so a stale word is never mistaken for a fresh one
  task automatic idle();
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, lane_write_enable_n, all_lanes_write_n} = 5'h1f;
    dq_in = ~dq_in;
  endtask
  initial begin
    {pipelined_chip_enable_n, depth_chip_enable_hi, depth_chip_enable_lo_n} = 3'h2;
    {addr, burst_mode, lane_write_select_n, dq_in} = '0;
    idle();
  end
  // Controller strobe only, since a processor strobe cycle never writes
  task automatic write(input logic [19:0] a, input logic [35:0] d, input logic gw_n, bwe_n, input logic [3:0] sel_n);
    @(posedge ref_clk) #1;
    {addr, dq_in, controller_addr_strobe_n, all_lanes_write_n, lane_write_enable_n, lane_write_select_n} =
      {a, d, 1'b0, gw_n, bwe_n, sel_n};
    @(posedge ref_clk) #1;
    idle();
  endtask
  task automatic read(input logic [19:0] a, input logic mode, input logic proc);
    @(posedge ref_clk) #1;
    {addr, burst_mode, processor_addr_strobe_n, controller_addr_strobe_n} = {a, mode, ~proc, proc};
    @(posedge ref_clk) #1;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, addr} = {3'h6, ~a};
    repeat (3) @(posedge ref_clk) #1;
    idle();
  endtask
endmodule

// ### testbench/tb_pipelined_burst_sync_sram.sv
// Bench for the memory core: controller model, read collection and checks.
// Assumes a 250 MHz ref_clk and the checker bound to the core.
`timescale 1ns/100ps
module tb_pipelined_burst_sync_sram;
  logic ref_clk, nrst, clk_en, output_enable_n, sleep_request, dq_ready, dq_oe, dq_valid, wr_stall;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, pipelined_chip_enable_n;
  logic depth_chip_enable_hi, depth_chip_enable_lo_n, lane_write_enable_n, all_lanes_write_n, burst_mode;
  logic [pbs_pkg::ADDR_W-1:0] addr;
  logic [3:0] lane_write_select_n;
  logic [pbs_pkg::WORD_W-1:0] dq_in, dq_out;
  logic [pbs_pkg::WORD_W-1:0] model [16];
  int err_count, checks;
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  pbs_ctrl_model i_ctrl (.ref_clk, .addr, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .pipelined_chip_enable_n, .depth_chip_enable_hi, .depth_chip_enable_lo_n, .lane_write_select_n,
    .lane_write_enable_n, .all_lanes_write_n, .burst_mode, .dq_in);
  pbs_sram i_dut (.ref_clk, .nrst, .clk_en, .addr, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .pipelined_chip_enable_n, .depth_chip_enable_hi, .depth_chip_enable_lo_n, .lane_write_select_n,
    .lane_write_enable_n, .all_lanes_write_n, .burst_mode, .output_enable_n, .sleep_request, .dq_in, .dq_ready,
    .dq_out, .dq_oe, .dq_valid, .wr_stall);
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [19:0] a, input logic [35:0] d, input logic gw_n, bwe_n, input logic [3:0] sel_n);
    for (int l = 0; l < 4; l++)
      if (!gw_n || (!bwe_n && !sel_n[l])) model[a[3:0]][l*9 +: 9] = d[l*9 +: 9];
    i_ctrl.write(a, d, gw_n, bwe_n, sel_n);
    // A strobe with no lanes enabled is a read; let its word drain first
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic burst(input logic [19:0] a, input logic mode, input logic proc);
    logic [1:0] idx;
    int n;
    n = 0;
    fork
      i_ctrl.read(a, mode, proc);
      repeat (16) begin
        @(posedge ref_clk) #1;
        if (dq_valid === 1'b1) begin
          idx = mode ? a[1:0] + n[1:0] : a[1:0] ^ n[1:0];
          if (n < 4) check("burst word", model[{a[3:2], idx}], dq_out);
          n++;
        end
      end
    join
    check("burst count", 36'h0_0000_0004, 36'(n));
    check("wr_stall", 36'h0_0000_0000, 36'(wr_stall));
  endtask
  // Lane selects left high: only the global write can fill the words
  task automatic t_global_write();
    for (int i = 0; i < 8; i++)
      put(20'(i), 36'h5_0000_0000 + 36'(i * 36'h1_0101_0101), 1'b0, 1'b1, 4'hf);
  endtask
  task automatic t_burst_orders();
    burst(20'h0_0001, pbs_pkg::MODE_INTERLEAVED, 1'b1);
    burst(20'h0_0006, pbs_pkg::MODE_LINEAR, 1'b0);
    burst(20'h0_0003, pbs_pkg::MODE_INTERLEAVED, 1'b0);
    burst(20'h0_0004, pbs_pkg::MODE_LINEAR, 1'b1);
  endtask
  task automatic t_lane_writes();
    put(20'h0_0005, 36'ha_aaaa_aaaa, 1'b1, 1'b0, 4'ha);
    put(20'h0_0006, 36'h3_3333_3333, 1'b1, 1'b1, 4'h0);
    burst(20'h0_0005, pbs_pkg::MODE_LINEAR, 1'b1);
  endtask
  task automatic t_async_pins();
    @(posedge ref_clk) #1 sleep_request = 1'b1;
    @(posedge ref_clk) #1 check("oe in sleep", 36'h0_0000_0000, 36'(dq_oe));
    {sleep_request, output_enable_n} = 2'h1;
    @(posedge ref_clk) #1 check("oe disabled", 36'h0_0000_0000, 36'(dq_oe));
    {output_enable_n, clk_en} = 2'h0;
    repeat (2) @(posedge ref_clk) #1;
    clk_en = 1'b1;
    @(posedge ref_clk) #1 check("oe enabled", 36'h0_0000_0001, 36'(dq_oe));
  endtask
  task automatic conclude();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {nrst, clk_en, output_enable_n, sleep_request, dq_ready} = 5'h09;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_global_write();
    t_burst_orders();
    t_lane_writes();
    t_async_pins();
    conclude();
  end
  // Run needs about 150 cycles; 5000 leaves ample margin
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
